//--- cpx_pkg.sv
/*
 * cpx_pkg: constants shared by the instruction execution subset.
 * Holds register offsets, field positions, reset values, opcodes and
 * state names. Assumes a 32-bit AHB-Lite register bus.
 */
`default_nettype none

package cpx_pkg;

    //////////////////////////////////////////////////////////////////////
    // widths and sizes
    localparam int CPX_DATA_W      = 8;
    localparam int CPX_PC_W        = 13;
    localparam int CPX_LIT_W       = 11;
    localparam int CPX_FILE_AW     = 7;
    localparam int CPX_FILE_DEPTH  = 128;
    localparam int CPX_LATCH_W     = 5;
    localparam int CPX_CYC_W       = 16;
    localparam int CPX_OFF_W       = 10;

    //////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [9:0] CPX_OFF_INSTR   = 10'h000;
    localparam logic [9:0] CPX_OFF_ACC     = 10'h004;
    localparam logic [9:0] CPX_OFF_STATUS  = 10'h008;
    localparam logic [9:0] CPX_OFF_PC      = 10'h00C;
    localparam logic [9:0] CPX_OFF_LATCH   = 10'h010;
    localparam logic [9:0] CPX_OFF_STACK   = 10'h014;
    localparam logic [9:0] CPX_OFF_WDT     = 10'h018;
    localparam logic [9:0] CPX_OFF_CYCLES  = 10'h01C;
    // file window: offset 0x200 + 4 * file address
    localparam int         CPX_FILE_SEL_BIT = 9;

    //////////////////////////////////////////////////////////////////////
    // instruction word fields
    localparam int CPX_IR_OP_LSB   = 0;
    localparam int CPX_IR_DEST_BIT = 4;
    localparam int CPX_IR_FILE_LSB = 8;
    localparam int CPX_IR_LIT_LSB  = 16;

    // status word fields
    localparam int CPX_ST_ZERO     = 0;
    localparam int CPX_ST_PD       = 3;
    localparam int CPX_ST_TO       = 4;
    localparam int CPX_ST_BUSY     = 8;
    localparam int CPX_ST_SKIP     = 9;
    localparam int CPX_ST_LOST     = 10;

    // pc_high_latch bits that feed pc bits 12:11
    localparam int CPX_LATCH_HI    = 4;
    localparam int CPX_LATCH_LO    = 3;

    //////////////////////////////////////////////////////////////////////
    // opcodes carried in the instruction word
    localparam logic [3:0] CPX_OP_NOP              = 4'h0;
    localparam logic [3:0] CPX_OP_WATCHDOG_CLEAR   = 4'h1;
    localparam logic [3:0] CPX_OP_CALL             = 4'h2;
    localparam logic [3:0] CPX_OP_COMPLEMENT_FILE  = 4'h3;
    localparam logic [3:0] CPX_OP_CLEAR_FILE       = 4'h4;
    localparam logic [3:0] CPX_OP_CLEAR_ACC        = 4'h5;
    localparam logic [3:0] CPX_OP_DECREMENT_FILE   = 4'h6;
    localparam logic [3:0] CPX_OP_DECREMENT_SKIP   = 4'h7;

    //////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  CPX_RST_ACC    = 8'h00;
    localparam logic [12:0] CPX_RST_PC     = 13'h0000;
    localparam logic        CPX_RST_TO     = 1'b1;
    localparam logic        CPX_RST_PD     = 1'b1;
    localparam logic [7:0]  CPX_WDT_CLEAR  = 8'h00;

    // execution sequencer states
    typedef enum logic [1:0] {
        CPX_ST_IDLE,
        CPX_ST_EXEC,
        CPX_ST_CALL2,
        CPX_ST_NOP
    } cpx_state_t;

endpackage : cpx_pkg

`default_nettype wire

//--- cpx_alu.sv
/*
 * cpx_alu: combinational result path for the file register operations.
 * Assumes the caller supplies the addressed file value and opcode.
 */
`timescale 1ns/10ps
`default_nettype none

module cpx_alu
    import cpx_pkg::*;
(
    input  wire logic [3:0] op,        // opcode
    input  wire logic       dest,      // 0 accumulator, 1 file
    input  wire logic [7:0] fval,      // addressed file value
    output logic      [7:0] result,    // operation result
    output logic            res_zero,  // result equals zero
    output logic            upd_zero,  // op updates zero flag
    output logic            to_file,   // write result to file
    output logic            to_acc     // write result to accumulator
);

    // result, destination and flag selection per opcode
    always_comb begin
        result   = 8'h00;
        upd_zero = 1'b0;
        to_file  = 1'b0;
        to_acc   = 1'b0;
        case (op)
            CPX_OP_COMPLEMENT_FILE: begin
                result   = ~fval;
                upd_zero = 1'b1;
                to_file  = dest;
                to_acc   = ~dest;
            end
            CPX_OP_CLEAR_FILE: begin
                upd_zero = 1'b1;
                to_file  = 1'b1;
            end
            CPX_OP_CLEAR_ACC: begin
                upd_zero = 1'b1;
                to_acc   = 1'b1;
            end
            CPX_OP_DECREMENT_FILE: begin
                result   = fval - 8'h01;
                upd_zero = 1'b1;
                to_file  = dest;
                to_acc   = ~dest;
            end
            CPX_OP_DECREMENT_SKIP: begin
                result   = fval - 8'h01;
                to_file  = dest;
                to_acc   = ~dest;
            end
            default: begin
                result   = 8'h00;
            end
        endcase
    end

    assign res_zero = (result == 8'h00);

endmodule : cpx_alu

`default_nettype wire

//--- cpx_exec_core.sv
/*
 * cpx_exec_core: executes a subset of an 8-bit core's instructions,
 * written one at a time over AHB-Lite, against its own accumulator,
 * file registers, program counter, return stack top, status flags and
 * watchdog counter. Assumes a single AHB-Lite master and one clock.
 */
// Summary of operation
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets timeout and powerdown bits, nothing else
// - call pushes program counter plus one as the new stack top
// - call loads its 11-bit literal into program counter bits 10:0
// - call loads pc bits 12:11 from latch bits 4:3
// - call lasts two cycles and changes no status flag
// - complement writes the inverted file value and updates zero
// - destination 0 writes accumulator, 1 writes file; address 0-127
// - clear file writes zero into the file and sets zero
// - clear accumulator writes zero and sets zero
// - decrement subtracts one, stores at destination, updates zero
// - decrement-skip stores, keeps flags, discards next on zero
`timescale 1ns/10ps
`default_nettype none

module cpx_exec_core
    import cpx_pkg::*;
(
    input  wire logic        hclk,        // bus clock, 20 MHz
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [31:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size, word only
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready
    output logic      [31:0] hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp,       // response, always okay
    output logic             exec_busy,   // instruction in progress
    output logic             wdt_cleared  // pulse on watchdog clear
);

    //////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]      file_mem [CPX_FILE_DEPTH];
    logic [7:0]      acc;
    logic            zero;
    logic            timeout_status_bit;
    logic            powerdown_status_bit;
    logic [12:0]     pc;
    logic [4:0]      pc_high_latch;
    logic [12:0]     stack_top;
    logic [7:0]      watchdog_counter;
    logic [7:0]      wdt_prescale;
    logic [15:0]     cycle_count;
    logic            skip_pending;
    logic            lost_instr;
    logic [3:0]      ir_op;
    logic            ir_dest;
    logic [6:0]      ir_file;
    logic [10:0]     ir_lit;
    cpx_state_t      state;
    cpx_state_t      next_state;
    logic            wr_pend;
    logic [9:0]      wr_addr;
    logic            bus_take;
    logic            wr_instr;
    logic            wr_acc;
    logic            wr_status;
    logic            wr_pc;
    logic            wr_latch;
    logic            wr_file;
    logic [6:0]      wr_file_idx;
    logic            accept;
    logic            exec_now;
    logic [7:0]      alu_result;
    logic            alu_zero;
    logic            alu_upd_zero;
    logic            alu_to_file;
    logic            alu_to_acc;
    logic            is_call;
    logic            is_wdclr;
    logic [31:0]     rd_mux;

    //////////////////////////////////////////////////////////////////////
    // bus address phase
    assign bus_take = hsel & hready & htrans[1];

    // address phase capture for the following data phase write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 10'h000;
        end else begin
            wr_pend <= bus_take & hwrite;
            wr_addr <= haddr[9:0];
        end
    end

    // write decode in the data phase
    assign wr_instr    = wr_pend && (wr_addr == CPX_OFF_INSTR);
    assign wr_acc      = wr_pend && (wr_addr == CPX_OFF_ACC);
    assign wr_status   = wr_pend && (wr_addr == CPX_OFF_STATUS);
    assign wr_pc       = wr_pend && (wr_addr == CPX_OFF_PC);
    assign wr_latch    = wr_pend && (wr_addr == CPX_OFF_LATCH);
    assign wr_file     = wr_pend && wr_addr[CPX_FILE_SEL_BIT];
    assign wr_file_idx = wr_addr[8:2];

    // zero wait state slave with okay answers only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // read data mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[CPX_FILE_SEL_BIT]) begin
            rd_mux[7:0] = file_mem[haddr[8:2]];
        end else begin
            case (haddr[9:0])
                CPX_OFF_INSTR: begin
                    rd_mux[CPX_IR_OP_LSB +: 4]   = ir_op;
                    rd_mux[CPX_IR_DEST_BIT]      = ir_dest;
                    rd_mux[CPX_IR_FILE_LSB +: 7] = ir_file;
                    rd_mux[CPX_IR_LIT_LSB +: 11] = ir_lit;
                end
                CPX_OFF_ACC: rd_mux[7:0] = acc;
                CPX_OFF_STATUS: begin
                    rd_mux[CPX_ST_ZERO] = zero;
                    rd_mux[CPX_ST_PD]   = powerdown_status_bit;
                    rd_mux[CPX_ST_TO]   = timeout_status_bit;
                    rd_mux[CPX_ST_BUSY] = (state != CPX_ST_IDLE);
                    rd_mux[CPX_ST_SKIP] = skip_pending;
                    rd_mux[CPX_ST_LOST] = lost_instr;
                end
                CPX_OFF_PC:     rd_mux[12:0] = pc;
                CPX_OFF_LATCH:  rd_mux[4:0]  = pc_high_latch;
                CPX_OFF_STACK:  rd_mux[12:0] = stack_top;
                CPX_OFF_WDT: begin
                    rd_mux[7:0]  = watchdog_counter;
                    rd_mux[15:8] = wdt_prescale;
                end
                CPX_OFF_CYCLES: rd_mux[15:0] = cycle_count;
                default:        rd_mux       = 32'h0000_0000;
            endcase
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // sequencer: an instruction write is taken only while idle
    assign accept   = wr_instr && (state == CPX_ST_IDLE);
    assign exec_now = (state == CPX_ST_EXEC);
    assign is_call  = (ir_op == CPX_OP_CALL);
    assign is_wdclr = (ir_op == CPX_OP_WATCHDOG_CLEAR);

    always_comb begin
        next_state = state;
        case (state)
            CPX_ST_IDLE: begin
                if (accept && skip_pending) begin
                    next_state = CPX_ST_NOP;
                end else if (accept) begin
                    next_state = CPX_ST_EXEC;
                end
            end
            CPX_ST_EXEC: begin
                next_state = is_call ? CPX_ST_CALL2 : CPX_ST_IDLE;
            end
            CPX_ST_CALL2: next_state = CPX_ST_IDLE;
            CPX_ST_NOP:   next_state = CPX_ST_IDLE;
            default:      next_state = CPX_ST_IDLE;
        endcase
    end

    // state register and registered busy output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= CPX_ST_IDLE;
            exec_busy <= 1'b0;
        end else begin
            state     <= next_state;
            exec_busy <= (next_state != CPX_ST_IDLE);
        end
    end

    // instruction register, loaded on a taken, non-discarded word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_op   <= CPX_OP_NOP;
            ir_dest <= 1'b0;
            ir_file <= 7'h00;
            ir_lit  <= 11'h000;
        end else if (accept && !skip_pending) begin
            ir_op   <= hwdata[CPX_IR_OP_LSB +: 4];
            ir_dest <= hwdata[CPX_IR_DEST_BIT];
            ir_file <= hwdata[CPX_IR_FILE_LSB +: 7];
            ir_lit  <= hwdata[CPX_IR_LIT_LSB +: 11];
        end
    end

    // skip request and lost instruction flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_pending <= 1'b0;
            lost_instr   <= 1'b0;
        end else begin
            if (exec_now && ir_op == CPX_OP_DECREMENT_SKIP) begin
                skip_pending <= alu_zero;
            end else if (accept) begin
                skip_pending <= 1'b0;
            end
            // words written while busy are dropped; set beats clear
            if (wr_instr && state != CPX_ST_IDLE) begin
                lost_instr <= 1'b1;
            end else if (wr_status && hwdata[CPX_ST_LOST]) begin
                lost_instr <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // result path
    cpx_alu u_alu (
        .op       (ir_op),
        .dest     (ir_dest),
        .fval     (file_mem[ir_file]),
        .result   (alu_result),
        .res_zero (alu_zero),
        .upd_zero (alu_upd_zero),
        .to_file  (alu_to_file),
        .to_acc   (alu_to_acc)
    );

    // file registers; execution wins over a bus write the same cycle
    always_ff @(posedge hclk) begin
        if (exec_now && alu_to_file) begin
            file_mem[ir_file] <= alu_result;
        end else if (wr_file) begin
            file_mem[wr_file_idx] <= hwdata[7:0];
        end
    end

    // accumulator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= CPX_RST_ACC;
        end else if (exec_now && alu_to_acc) begin
            acc <= alu_result;
        end else if (wr_acc) begin
            acc <= hwdata[7:0];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero                 <= 1'b0;
            timeout_status_bit   <= CPX_RST_TO;
            powerdown_status_bit <= CPX_RST_PD;
        end else if (exec_now) begin
            if (alu_upd_zero) begin
                zero <= alu_zero;
            end
            if (is_wdclr) begin
                timeout_status_bit   <= 1'b1;
                powerdown_status_bit <= 1'b1;
            end
        end else if (wr_status) begin
            zero                 <= hwdata[CPX_ST_ZERO];
            timeout_status_bit   <= hwdata[CPX_ST_TO];
            powerdown_status_bit <= hwdata[CPX_ST_PD];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // program counter, latch and stack top
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= CPX_RST_PC;
        end else if (exec_now && is_call) begin
            pc <= {pc_high_latch[CPX_LATCH_HI:CPX_LATCH_LO], ir_lit};
        end else if (exec_now || state == CPX_ST_NOP) begin
            pc <= pc + 13'h0001;
        end else if (wr_pc && state == CPX_ST_IDLE) begin
            pc <= hwdata[12:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_high_latch <= 5'h00;
        end else if (wr_latch) begin
            pc_high_latch <= hwdata[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_top <= 13'h0000;
        end else if (exec_now && is_call) begin
            stack_top <= pc + 13'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // watchdog counter and prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_counter <= CPX_WDT_CLEAR;
            wdt_prescale     <= CPX_WDT_CLEAR;
            wdt_cleared      <= 1'b0;
        end else if (exec_now && is_wdclr) begin
            watchdog_counter <= CPX_WDT_CLEAR;
            wdt_prescale     <= CPX_WDT_CLEAR;
            wdt_cleared      <= 1'b1;
        end else begin
            wdt_prescale <= wdt_prescale + 8'h01;
            if (wdt_prescale == 8'hFF) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
            wdt_cleared <= 1'b0;
        end
    end

    // instruction cycle counter, counts every busy cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cycle_count <= 16'h0000;
        end else if (state != CPX_ST_IDLE) begin
            cycle_count <= cycle_count + 16'h0001;
        end
    end

endmodule : cpx_exec_core

`default_nettype wire

//--- cpx_exec_core_properties.sv
/*
 * cpx_exec_checker: port checks for the execution core.
 * Assumes one clock and the core's active low asynchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none

module cpx_exec_checker
    import cpx_pkg::*;
(
    input  wire logic        hclk,        // bus clock
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [31:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic        hready,      // bus ready
    input  wire logic [31:0] hrdata,      // read data
    input  wire logic        hreadyout,   // slave ready
    input  wire logic        hresp,       // response
    input  wire logic        exec_busy,   // instruction in progress
    input  wire logic        wdt_cleared  // watchdog clear pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic instr_ap;   // instruction write address phase
    logic read_ap;    // read address phase
    logic instr_dp;   // instruction write data phase

    // decode of accepted address phases
    assign instr_ap = hsel && hready && htrans[1] && hwrite &&
                      (haddr[9:0] == CPX_OFF_INSTR);
    assign read_ap  = hsel && hready && htrans[1] && !hwrite;

    // marks the data phase of an instruction write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_dp <= 1'b0;
        end else begin
            instr_dp <= instr_ap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!hresp)
        else $error("slave answered with an error");
    a_rdata_hold: assert property (!read_ap |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_instr_starts: assert property (instr_dp && !exec_busy |=>
        exec_busy)
        else $error("idle core did not take an instruction");
    a_busy_cause: assert property ($rose(exec_busy) |->
        $past(instr_dp))
        else $error("core went busy without an instruction");
    a_busy_bounded: assert property ($rose(exec_busy) |->
        ##[1:2] !exec_busy)
        else $error("instruction lasted more than two cycles");
    a_wdt_pulse: assert property (wdt_cleared |=> !wdt_cleared)
        else $error("watchdog clear pulse too long");
    a_wdt_after_exec: assert property ($rose(wdt_cleared) |->
        ($past(exec_busy) || $past(exec_busy, 2)))
        else $error("watchdog clear without execution");

    c_busy: cover property ($rose(exec_busy));
    c_long: cover property ($rose(exec_busy) ##1 exec_busy);
    c_wdt: cover property (wdt_cleared);
endmodule : cpx_exec_checker

bind cpx_exec_core cpx_exec_checker i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy),
    .wdt_cleared(wdt_cleared)
);

`default_nettype wire

//--- cpx_host_model.sv
/*
 * cpx_host_model: fetch side bus master issuing single word transfers.
 * Assumes the core is the only slave and its ready closes each phase.
 */
`timescale 1ns/10ps
`default_nettype none

module cpx_host_model (
    input  wire logic        hclk,       // bus clock
    input  wire logic [31:0] hrdata,     // read data
    input  wire logic        hreadyout,  // slave ready
    output logic      [31:0] haddr,      // byte address
    output logic      [1:0]  htrans,     // transfer type
    output logic             hwrite,     // write when high
    output logic      [2:0]  hsize,      // word transfers only
    output logic      [31:0] hwdata      // write data
);
    // idle bus at time zero
    initial begin
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // one phase: wait for ready at a rising edge, bounded
    task automatic phase(inout logic ok);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) ok = 1'b0;
    endtask : phase

    // single transfer; released lines carry inverted values
    task automatic xfer(input logic wr, input logic [31:0] a, d,
                        output logic [31:0] rd, output logic ok);
        ok = 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        phase(ok);
        htrans <= 2'h0;
        haddr  <= ~a;
        hwdata <= wr ? d : ~d;
        phase(ok);
        rd = hrdata;
        hwdata <= ~d;
    endtask : xfer
endmodule : cpx_host_model

`default_nettype wire

//--- tb_cpu_instr_exec_subset.sv
/*
 * tb_cpu_instr_exec_subset: random and corner instruction runs.
 * Assumes the host model drives the bus and the checker is bound.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_cpu_instr_exec_subset;
    import cpx_pkg::*;
    logic        hclk;       // bus clock
    logic        hresetn;    // reset, active low
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hwrite, hreadyout, hresp, exec_busy, wdt_cleared;
    int          failures = 0;
    int          tests_run = 0;
    logic [15:0] seed;
    logic [12:0] epc;        // expected program counter

    cpx_host_model i_host (.hclk(hclk), .hrdata(hrdata),
        .hreadyout(hreadyout), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    cpx_exec_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy),
        .wdt_cleared(wdt_cleared));

    // 50 ns clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    // expected operation result
    function automatic logic [7:0] alu(logic [3:0] op, logic [7:0] v);
        case (op)
            CPX_OP_COMPLEMENT_FILE: return ~v;
            CPX_OP_DECREMENT_FILE, CPX_OP_DECREMENT_SKIP: return v - 8'h01;
            default: return 8'h00;
        endcase
    endfunction : alu

    task automatic bus(logic wr, logic [31:0] a, d, output logic [31:0] r);
        logic ok;
        i_host.xfer(wr, a, d, r, ok);
        if (!ok) begin
            failures++;
            complete_run();
        end
    endtask : bus

    task automatic wr(logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic chk(logic [31:0] a, e, m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        tests_run++;
        if ((r & m) !== (e & m)) begin
            failures++;
            $display("mismatch %0t: got %h expected %h", $time, r & m, e & m);
        end
    endtask : chk

    // write an instruction, then wait until the core is idle again
    task automatic exec(logic [31:0] w);
        int n;
        wr(CPX_OFF_INSTR, w);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (exec_busy !== 1'b0 && n < 16);
        if (n >= 16) begin
            failures++;
            complete_run();
        end
    endtask : exec

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0]  op;
        logic [6:0]  f;
        logic [7:0]  v, a0, res;
        logic        d, zp, ez;
        logic [4:0]  lat;
        logic [10:0] lit;
        hresetn = 1'b0;
        seed = 16'h3D5C;
        epc = 13'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(CPX_OFF_STATUS, 32'h18, 32'h19);
        chk(CPX_OFF_PC, 32'h0, 32'h1FFF);
        // file operations: v=1 and v=0 corners first, then random
        for (int i = 0; i < 30; i++) begin
            {f, d, v} = rnd();
            {a0, zp} = 9'(rnd());
            op = 4'(3 + i % 5);
            if (i < 5) v = 8'h01;
            else if (i < 10) v = 8'h00;
            if (i == 0) f = 7'h7F;
            wr({23'h1, f, 2'b0}, {24'h0, v});
            wr(CPX_OFF_ACC, {24'h0, a0});
            wr(CPX_OFF_STATUS, {27'h0, 2'b11, 2'b00, zp});
            exec({16'h0, 1'b0, f, 3'b000, d, op});
            res = alu(op, v);
            ez = (op == CPX_OP_DECREMENT_SKIP) ? zp : (res == 8'h00);
            epc++;
            if (op == CPX_OP_DECREMENT_SKIP && res == 8'h00) begin
                exec({28'h0, CPX_OP_CLEAR_ACC});
                epc++;
            end
            chk({23'h1, f, 2'b0},
                (op == 4'h4 || (d && op != 4'h5)) ? res : v, 32'hFF);
            chk(CPX_OFF_ACC,
                (op == 4'h5 || (!d && op != 4'h4)) ? res : a0, 32'hFF);
            chk(CPX_OFF_STATUS, {31'hC, ez}, 32'h19);
            chk(CPX_OFF_PC, {19'h0, epc}, 32'h1FFF);
        end
        // calls with literal corners and random latch bits
        for (int i = 0; i < 4; i++) begin
            {lat, lit} = rnd();
            if (i == 0) lit = 11'h7FF;
            if (i == 1) lit = 11'h000;
            wr(CPX_OFF_LATCH, {27'h0, lat});
            exec({5'h0, lit, 12'h0, CPX_OP_CALL});
            chk(CPX_OFF_STACK, {19'h0, epc + 13'h1}, 32'h1FFF);
            epc = {lat[4:3], lit};
            chk(CPX_OFF_PC, {19'h0, epc}, 32'h1FFF);
            chk(CPX_OFF_STATUS, {31'hC, ez}, 32'h19);
        end
        // watchdog clear from cleared status bits
        wr(CPX_OFF_STATUS, 32'h1);
        exec({28'h0, CPX_OP_WATCHDOG_CLEAR});
        chk(CPX_OFF_STATUS, 32'h19, 32'h19);
        chk(CPX_OFF_WDT, 32'h0, 32'hFF);
        complete_run();
    end

    // overall cycle limit
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        complete_run();
    end
endmodule : tb_cpu_instr_exec_subset

`default_nettype wire
